// [src/rpc_map.svh]
`ifndef RPC_MAP_SVH
`define RPC_MAP_SVH

`define RPC_NPORT        14
`define RPC_NLOCK        15
`define RPC_NXCVR        16
`define RPC_EP_BIT       14
`define RPC_REV_BIT      13

`define RPC_BANK_CTRL    8'h03
`define RPC_BANK_STAT    8'h04
`define RPC_BANK_RMON    8'h05
`define RPC_ADDR_BASE    8'hE0

`define RPC_OFS_ISO      8'hE7
`define RPC_OFS_EXT      8'hE8
`define RPC_OFS_LIE      8'hE9
`define RPC_OFS_PIE      8'hEA
`define RPC_OFS_LCK      8'hEB
`define RPC_OFS_PART     8'hE0
`define RPC_OFS_LINK     8'hE2
`define RPC_OFS_LOOP     8'hE3
`define RPC_OFS_POL      8'hE4
`define RPC_OFS_SQE      8'hE5
`define RPC_OFS_OCT      8'hE0
`define RPC_OFS_PKT      8'hE1

`define RPC_ISO_MASK     16'h3FFF
`define RPC_LCK_MASK     16'h7FFF
`define RPC_ISO_CONNECT  16'h3FFF
`define RPC_ISO_ISOLATE  16'h0000
`define RPC_EXT_RST      16'h0000
`define RPC_LIE_RST      16'h0000
`define RPC_PIE_RST      16'h0000
`define RPC_LCK_RST      16'h0000
`define RPC_CNT_RST      32'h0000_0000
`define RPC_BYTE_UNMAP   8'h00

`endif

// [src/rpc_pkg.sv]
`default_nettype none
`include "rpc_map.svh"

package rpc_pkg;

  typedef enum logic [3:0] {
    RPC_K_NONE = 4'b0001,
    RPC_K_W16  = 4'b0010,
    RPC_K_R16  = 4'b0100,
    RPC_K_CNT  = 4'b1000
  } rpc_kind_e;

  typedef struct packed {
    logic [7:0]                      bank;
    logic [7:0]                      addr;
    logic [1:0]                      bptr;
    logic [7:0]                      dout;
    logic [31:0]                     hold;
    logic                            init_done;
    logic [15:0]                     iso;
    logic [15:0]                     ext;
    logic [15:0]                     lie;
    logic [15:0]                     pie;
    logic [15:0]                     lck;
    logic [`RPC_NPORT-1:0]           conn;
    logic [`RPC_NPORT-1:0]           tx_d;
    logic [`RPC_NPORT-1:0]           lpb_acc;
    logic [`RPC_NPORT-1:0]           loop_err;
    logic [`RPC_NPORT-1:0]           sqe;
    logic [31:0]                     oct;
    logic [31:0]                     pkt;
    logic [`RPC_NLOCK-1:0][47:0]     lsa;
    logic [`RPC_NPORT-1:0]           intr;
    logic                            sa_chg;
    logic [3:0]                      sa_chg_port;
  } rpc_state_s;

endpackage : rpc_pkg

`default_nettype wire

// [src/rpc_top.sv]
// Notes on behaviour
// [RULE_01] Expansion enable never stops the bus; clear bit drops MAC-bound traffic from counts.
// [RULE_02] Isolation bit 0 isolates its port, 1 connects it, for fourteen ports.
// [RULE_03] Isolated port ignores inputs and activity; link and polarity still reported.
// [RULE_04] Isolation bits load from the external port-enable pin at reset.
// [RULE_05] Isolating a port mid-packet stops repeating that packet at once.
// [RULE_06] Connecting waits for an arriving packet to end; otherwise immediate.
// [RULE_07] Extended distance bits drive the transceiver threshold; reset disabled.
// [RULE_08] Intrusion control disables a port on good packet with foreign source.
// [RULE_09] Two enables combine: none, either alone, or fail only matching neither.
// [RULE_10] Software loads a valid address before enabling intrusion control.
// [RULE_11] A differing source address overwrites the stored last source address.
// [RULE_12] Lock bit stops automatic update; processor writes still land; reset unlocked.
// [RULE_13] Lock bit marks that port's source address change count invalid.
// [RULE_14] Bank code 0000 0100 selects the port status bank.
// [RULE_15] Partition bit 0 partitioned, 1 connected; partitioned port transmits, not repeated.
// [RULE_16] Link status bit 0 failed, 1 passed, from transceiver data.
// [RULE_17] Transmit must loop back to receive; else loopback error 1; reversible invalid reversed.
// [RULE_18] Polarity bit 0 correct, 1 reversed, from transceiver serial data.
// [RULE_19] SQE bit holds last packet result, 1 error; reversible invalid reversed.
// [RULE_20] Bank code 0000 0101 selects counters; 32-bit, read four bytes LSB first.
// [RULE_21] Counters read-only except while repeater or management reset bit is set.
// [RULE_22] Octet counter counts received octets with FCS; packet counter counts packets.
// [RULE_23] Bank code then register address go to command register before data access.
// [RULE_24] Two-byte registers take two data accesses: byte 0 ports 0-7, then byte 1.
`default_nettype none
`include "rpc_map.svh"

module rpc_top
  import rpc_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  input  wire logic                    external_port_enable_pin,
  input  wire logic                    np_cmd_sel,
  input  wire logic                    np_wr,
  input  wire logic                    np_rd,
  input  wire logic [7:0]              np_din,
  output logic      [7:0]              np_dout,
  input  wire logic [`RPC_NPORT-1:0]   rx_act,
  input  wire logic [`RPC_NPORT-1:0]   tx_act,
  input  wire logic [`RPC_NPORT-1:0]   loop_rx,
  input  wire logic [`RPC_NPORT-1:0]   part_ok,
  input  wire logic [`RPC_NXCVR-1:0]   link_in,
  input  wire logic [`RPC_NXCVR-1:0]   pol_in,
  input  wire logic                    reverse_mode,
  input  wire logic [`RPC_NPORT-1:0]   sqe_done,
  input  wire logic [`RPC_NPORT-1:0]   sqe_err,
  input  wire logic                    pkt_done,
  input  wire logic [3:0]              pkt_port,
  input  wire logic                    pkt_good,
  input  wire logic [47:0]             pkt_sa,
  input  wire logic [47:0]             pref_sa,
  input  wire logic                    lsa_wr,
  input  wire logic [3:0]              lsa_wr_port,
  input  wire logic [47:0]             lsa_wr_data,
  input  wire logic                    octet_stb,
  input  wire logic                    packet_stb,
  input  wire logic                    repeater_reset_bit,
  input  wire logic                    mgmt_reset_bit,
  input  wire logic                    expansion_port_bit,
  input  wire logic                    exp_mac_pkt,
  output logic      [`RPC_NPORT-1:0]   port_connected,
  output logic      [`RPC_NPORT-1:0]   rx_gated,
  output logic      [`RPC_NPORT-1:0]   repeat_en,
  output logic      [`RPC_NPORT-1:0]   tx_gate,
  output logic      [`RPC_NXCVR-1:0]   ext_dist_out,
  output logic      [`RPC_NXCVR-1:0]   link_status,
  output logic      [`RPC_NXCVR-1:0]   pol_status,
  output logic      [`RPC_NPORT-1:0]   intrusion_disable,
  output logic                         sa_change,
  output logic      [3:0]              sa_change_port,
  output logic      [`RPC_NLOCK-1:0]   sa_change_invalid,
  output logic                         exp_count_ok
);

  if (CNT_W != 32) begin : g_cnt_w_chk
    $error("rpc_top: counters are read as four bytes, CNT_W must be 32");
  end

  rpc_state_s s_r;
  rpc_state_s s_nxt;
  rpc_kind_e  kind;
  logic [15:0] rd16;
  logic [31:0] cnt_sel;
  logic        cnt_wr_ok;
  logic        cmd_wr;
  logic        dat_wr;
  logic        dat_rd;
  logic        lmis;
  logic        pmis;
  logic        fail;
  logic        pkt_ok_port;

  assign cmd_wr    = np_wr & np_cmd_sel;
  assign dat_wr    = np_wr & ~np_cmd_sel;
  assign dat_rd    = np_rd & ~np_cmd_sel;
  assign cnt_wr_ok = repeater_reset_bit | mgmt_reset_bit; // RULE_21

  // Target decode from the selected bank and register address
  always_comb begin
    kind    = RPC_K_NONE;
    rd16    = 16'h0000;
    cnt_sel = s_r.oct;
    case (s_r.bank)
      `RPC_BANK_CTRL: begin
        kind = RPC_K_W16;
        case (s_r.addr)
          `RPC_OFS_ISO: rd16 = s_r.iso;
          `RPC_OFS_EXT: rd16 = s_r.ext;
          `RPC_OFS_LIE: rd16 = s_r.lie;
          `RPC_OFS_PIE: rd16 = s_r.pie;
          `RPC_OFS_LCK: rd16 = s_r.lck;
          default:      kind = RPC_K_NONE;
        endcase
      end
      `RPC_BANK_STAT: begin // RULE_14
        kind = RPC_K_R16;
        case (s_r.addr)
          `RPC_OFS_PART: rd16 = {2'b00, part_ok}; // RULE_15
          `RPC_OFS_LINK: rd16 = link_in; // RULE_16
          `RPC_OFS_LOOP: rd16 = {2'b00, s_r.loop_err}; // RULE_17
          `RPC_OFS_POL:  rd16 = pol_in; // RULE_18
          `RPC_OFS_SQE:  rd16 = {2'b00, s_r.sqe}; // RULE_19
          default:       kind = RPC_K_NONE;
        endcase
      end
      `RPC_BANK_RMON: begin // RULE_20
        kind = RPC_K_CNT;
        case (s_r.addr)
          `RPC_OFS_OCT: cnt_sel = s_r.oct;
          `RPC_OFS_PKT: cnt_sel = s_r.pkt;
          default:      kind = RPC_K_NONE;
        endcase
      end
      default: kind = RPC_K_NONE;
    endcase
  end

  // Intrusion check for the packet just ended
  always_comb begin
    pkt_ok_port = pkt_done & pkt_good & (pkt_port < 4'(`RPC_NPORT));
    lmis = 1'b0;
    pmis = pkt_sa != pref_sa;
    if (pkt_port < 4'(`RPC_NLOCK)) begin
      lmis = pkt_sa != s_r.lsa[pkt_port];
    end
    fail = 1'b0;
    if (pkt_ok_port) begin // RULE_08
      case ({s_r.lie[pkt_port], s_r.pie[pkt_port]}) // RULE_09
        2'b11:   fail = lmis & pmis;
        2'b10:   fail = lmis;
        2'b01:   fail = pmis;
        default: fail = 1'b0;
      endcase
    end
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.intr   = '0;
    s_nxt.sa_chg = 1'b0;

    // Strap capture one edge after reset release
    if (!s_r.init_done) begin
      s_nxt.init_done = 1'b1;
      s_nxt.iso = external_port_enable_pin ? `RPC_ISO_CONNECT : `RPC_ISO_ISOLATE; // RULE_04
    end

    // Command register: bank code or register address
    if (cmd_wr) begin // RULE_23
      s_nxt.bptr = 2'd0;
      if (np_din >= `RPC_ADDR_BASE) begin
        s_nxt.addr = np_din;
      end else begin
        s_nxt.bank = np_din;
        s_nxt.addr = 8'h00;
      end
    end

    if (dat_wr) begin
      case (kind)
        RPC_K_W16: begin // RULE_24
          s_nxt.bptr = {1'b0, ~s_r.bptr[0]};
          case (s_r.addr)
            `RPC_OFS_ISO: begin
              if (s_r.bptr[0]) s_nxt.iso[15:8] = np_din & 8'(`RPC_ISO_MASK >> 8);
              else s_nxt.iso[7:0] = np_din;
            end
            `RPC_OFS_EXT: begin
              if (s_r.bptr[0]) s_nxt.ext[15:8] = np_din;
              else s_nxt.ext[7:0] = np_din;
            end
            `RPC_OFS_LIE: begin
              if (s_r.bptr[0]) s_nxt.lie[15:8] = np_din & 8'(`RPC_ISO_MASK >> 8);
              else s_nxt.lie[7:0] = np_din;
            end
            `RPC_OFS_PIE: begin
              if (s_r.bptr[0]) s_nxt.pie[15:8] = np_din & 8'(`RPC_ISO_MASK >> 8);
              else s_nxt.pie[7:0] = np_din;
            end
            `RPC_OFS_LCK: begin
              if (s_r.bptr[0]) s_nxt.lck[15:8] = np_din & 8'(`RPC_LCK_MASK >> 8);
              else s_nxt.lck[7:0] = np_din;
            end
            default: s_nxt.bptr = s_r.bptr;
          endcase
        end
        RPC_K_R16: s_nxt.bptr = {1'b0, ~s_r.bptr[0]};
        RPC_K_CNT: begin // RULE_20
          s_nxt.bptr = s_r.bptr + 2'd1;
          if (cnt_wr_ok) begin // RULE_21
            if (s_r.addr == `RPC_OFS_OCT) s_nxt.oct[s_r.bptr*8 +: 8] = np_din;
            else s_nxt.pkt[s_r.bptr*8 +: 8] = np_din;
          end
        end
        default: s_nxt.bptr = s_r.bptr;
      endcase
    end

    if (dat_rd) begin
      case (kind)
        RPC_K_W16, RPC_K_R16: begin // RULE_24
          s_nxt.dout = s_r.bptr[0] ? rd16[15:8] : rd16[7:0];
          s_nxt.bptr = {1'b0, ~s_r.bptr[0]};
        end
        RPC_K_CNT: begin // RULE_20
          if (s_r.bptr == 2'd0) begin
            s_nxt.hold = cnt_sel;
            s_nxt.dout = cnt_sel[7:0];
          end else begin
            s_nxt.dout = s_r.hold[s_r.bptr*8 +: 8];
          end
          s_nxt.bptr = s_r.bptr + 2'd1;
        end
        default: s_nxt.dout = `RPC_BYTE_UNMAP;
      endcase
    end

    // Counting; a processor write in the same cycle takes the byte
    if (octet_stb && !(dat_wr && kind == RPC_K_CNT && cnt_wr_ok)) begin
      s_nxt.oct = s_r.oct + 32'h1; // RULE_22
    end
    if (packet_stb && !(dat_wr && kind == RPC_K_CNT && cnt_wr_ok)) begin
      s_nxt.pkt = s_r.pkt + 32'h1; // RULE_22
    end

    // Effective connection: drop at once, join only between arriving packets
    s_nxt.conn = s_r.iso[`RPC_NPORT-1:0] & (s_r.conn | ~rx_act); // RULE_02 RULE_05 RULE_06

    // Loopback check across each transmission
    s_nxt.tx_d = tx_act;
    for (int i = 0; i < `RPC_NPORT; i++) begin
      if (tx_act[i]) begin
        s_nxt.lpb_acc[i] = (s_r.tx_d[i] ? s_r.lpb_acc[i] : 1'b0) | ~loop_rx[i];
      end
      if (s_r.tx_d[i] && !tx_act[i]) begin
        s_nxt.loop_err[i] = s_r.lpb_acc[i]; // RULE_17
      end
      if (sqe_done[i]) begin
        s_nxt.sqe[i] = sqe_err[i]; // RULE_19
      end
    end
    if (reverse_mode) begin
      s_nxt.loop_err[`RPC_REV_BIT] = 1'b0; // RULE_17
      s_nxt.sqe[`RPC_REV_BIT]      = 1'b0; // RULE_19
    end

    if (fail) begin
      s_nxt.intr[pkt_port] = 1'b1; // RULE_08
    end

    // Last source address tracking; processor write wins on the same port
    if (pkt_done && pkt_port < 4'(`RPC_NLOCK) && lmis && !s_r.lck[pkt_port]) begin // RULE_11 RULE_12
      s_nxt.lsa[pkt_port] = pkt_sa;
      s_nxt.sa_chg        = 1'b1;
      s_nxt.sa_chg_port   = pkt_port;
    end
    if (lsa_wr && lsa_wr_port < 4'(`RPC_NLOCK)) begin
      s_nxt.lsa[lsa_wr_port] = lsa_wr_data; // RULE_12
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r             <= '0;
      s_r.iso         <= `RPC_ISO_ISOLATE;
      s_r.ext         <= `RPC_EXT_RST;
      s_r.lie         <= `RPC_LIE_RST;
      s_r.pie         <= `RPC_PIE_RST;
      s_r.lck         <= `RPC_LCK_RST;
      s_r.oct         <= `RPC_CNT_RST;
      s_r.pkt         <= `RPC_CNT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign np_dout           = s_r.dout;
  assign port_connected    = s_r.conn;
  assign rx_gated          = rx_act & s_r.conn; // RULE_03
  assign repeat_en         = rx_act & s_r.conn & part_ok; // RULE_15
  assign tx_gate           = s_r.conn; // RULE_15
  assign ext_dist_out      = s_r.ext; // RULE_07
  assign link_status       = link_in; // RULE_03
  assign pol_status        = pol_in; // RULE_03
  assign intrusion_disable = s_r.intr;
  assign sa_change         = s_r.sa_chg;
  assign sa_change_port    = s_r.sa_chg_port;
  assign sa_change_invalid = s_r.lck[`RPC_NLOCK-1:0]; // RULE_13
  assign exp_count_ok      = expansion_port_bit | ~exp_mac_pkt; // RULE_01

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_ISO_DROP: assert property ($past(s_r.init_done) |-> // RULE_05
    (s_r.conn & ~$past(s_r.iso[`RPC_NPORT-1:0])) == '0)
    else $error("isolated port still connected");
  AST_CONN_WAIT: assert property ((s_r.conn & ~$past(s_r.conn) & $past(rx_act)) == '0) // RULE_06
    else $error("port connected during arriving packet");
  AST_GATE: assert property ($fell(s_r.iso[3]) |-> ##1 !rx_gated[3]) // RULE_03
    else $error("isolated port input not ignored");
  AST_STRAP: assert property ($rose(s_r.init_done) |-> // RULE_04
    s_r.iso == ($past(external_port_enable_pin) ? `RPC_ISO_CONNECT : `RPC_ISO_ISOLATE))
    else $error("isolation bits not taken from pin");
  AST_EXT_RST: assert property ($rose(s_r.init_done) |-> ext_dist_out == `RPC_EXT_RST) // RULE_07
    else $error("extended distance not disabled after reset");
  AST_INTR_BOTH: assert property (pkt_done && pkt_good && pkt_port < 4'(`RPC_NPORT) && // RULE_09
    s_r.lie[pkt_port] && s_r.pie[pkt_port] &&
    (pkt_sa == pref_sa || pkt_sa == s_r.lsa[pkt_port]) |=> intrusion_disable == '0)
    else $error("port disabled though an address matched");
  AST_INTR_FIRE: assert property (pkt_done && pkt_good && pkt_port < 4'(`RPC_NPORT) && // RULE_08
    s_r.lie[pkt_port] && !s_r.pie[pkt_port] && pkt_sa != s_r.lsa[pkt_port]
    |=> intrusion_disable[$past(pkt_port)])
    else $error("intrusion not detected");
  AST_LOCK: assert property (pkt_done && pkt_port < 4'(`RPC_NLOCK) && s_r.lck[pkt_port] // RULE_12
    && !lsa_wr |=> s_r.lsa[$past(pkt_port)] == $past(s_r.lsa[pkt_port]))
    else $error("locked address updated");
  AST_LSA_UPD: assert property (pkt_done && pkt_port < 4'(`RPC_NLOCK) && // RULE_11
    !s_r.lck[pkt_port] && !lsa_wr |=> s_r.lsa[$past(pkt_port)] == $past(pkt_sa))
    else $error("last source address not updated");
  AST_CNT_RO: assert property (!cnt_wr_ok && !octet_stb |=> s_r.oct == $past(s_r.oct)) // RULE_21
    else $error("octet counter changed without cause");
  AST_OCT_INC: assert property (octet_stb && !dat_wr |=> s_r.oct == $past(s_r.oct) + 32'h1) // RULE_22
    else $error("octet counter did not advance");
  AST_CNT_ORDER: assert property (dat_rd && kind == RPC_K_CNT && s_r.bptr == 2'd0 // RULE_20
    |=> np_dout == $past(cnt_sel[7:0]))
    else $error("counter low byte not first");
  AST_SA_CHG: assert property (pkt_done && pkt_port < 4'(`RPC_NLOCK) && // RULE_11
    !s_r.lck[pkt_port] && pkt_sa != s_r.lsa[pkt_port]
    |=> sa_change && sa_change_port == $past(pkt_port))
    else $error("address change not flagged");
  AST_LOOP_REV: assert property (reverse_mode |=> !s_r.loop_err[`RPC_REV_BIT]) // RULE_17
    else $error("reversed port loopback bit set");
  AST_SQE_LAST: assert property ((|sqe_done[12:0]) |=> // RULE_19
    (s_r.sqe[12:0] & $past(sqe_done[12:0])) == ($past(sqe_err[12:0]) & $past(sqe_done[12:0])))
    else $error("SQE result not kept");
  AST_PART_RD: assert property (dat_rd && kind == RPC_K_R16 && // RULE_15
    s_r.addr == `RPC_OFS_PART && !s_r.bptr[0] |=> np_dout == $past(part_ok[7:0]))
    else $error("partition byte 0 wrong");
  AST_CNT_WR: assert property (dat_wr && kind == RPC_K_CNT && cnt_wr_ok && // RULE_21
    s_r.addr == `RPC_OFS_PKT && s_r.bptr == 2'd0 |=> s_r.pkt[7:0] == $past(np_din))
    else $error("counter write lost");
  AST_EXT_OUT: assert property (dat_wr && kind == RPC_K_W16 && // RULE_07
    s_r.addr == `RPC_OFS_EXT && !s_r.bptr[0] |=> ext_dist_out[7:0] == $past(np_din))
    else $error("extended distance byte 0 not driven");
  AST_EXP_CNT: assert property (!expansion_port_bit && exp_mac_pkt |-> !exp_count_ok) // RULE_01
    else $error("expansion traffic to MAC still counted");

endmodule : rpc_top

`default_nettype wire

// [tb/rpc_np_model.sv]
`default_nettype none
`include "rpc_map.svh"

module rpc_np_model
  import rpc_pkg::*;
(
  input  wire logic       mclk,
  output var  logic       np_cmd_sel,
  output var  logic       np_wr,
  output var  logic       np_rd,
  output var  logic [7:0] np_din,
  input  wire logic [7:0] np_dout
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    np_cmd_sel = 1'b0;
    np_wr      = 1'b0;
    np_rd      = 1'b0;
    np_din     = 8'h00;
  end

  // Released data bus shows the inverse of the last byte
  task automatic wr(input logic c, input logic [7:0] d);
    @(posedge mclk);
    np_cmd_sel <= c;
    np_wr      <= 1'b1;
    np_din     <= d;
    @(posedge mclk);
    np_wr      <= 1'b0;
    np_din     <= ~d;
  endtask : wr

  task automatic rd(output logic [7:0] d);
    @(posedge mclk);
    np_cmd_sel <= 1'b0;
    np_rd      <= 1'b1;
    @(posedge mclk);
    np_rd      <= 1'b0;
    #1;
    d = np_dout;
  endtask : rd

  task automatic sel(input logic [7:0] b, input logic [7:0] a);
    wr(1'b1, b);
    wr(1'b1, a);
  endtask : sel

  task automatic wrn(input logic [7:0] b, input logic [7:0] a, input int n,
                     input logic [31:0] v);
    sel(b, a);
    for (int i = 0; i < n; i++) begin
      wr(1'b0, v[8*i +: 8]);
    end
  endtask : wrn

  task automatic rdn(input logic [7:0] b, input logic [7:0] a, input int n,
                     output logic [31:0] v);
    logic [7:0] d;
    sel(b, a);
    v = '0;
    for (int i = 0; i < n; i++) begin
      rd(d);
      v[8*i +: 8] = d;
    end
  endtask : rdn
endmodule : rpc_np_model

`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
`include "rpc_map.svh"

module testbench
  import rpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk, nrst, pin, np_cmd_sel, np_wr, np_rd;
  logic [7:0]  np_din, np_dout;
  logic [13:0] rx_act, tx_act, loop_rx, part_ok, sqe_done, sqe_err;
  logic [13:0] port_connected, rx_gated, repeat_en, tx_gate, intrusion_disable;
  logic [15:0] link_in, pol_in, ext_dist_out, link_status, pol_status;
  logic        reverse_mode, pkt_done, pkt_good, lsa_wr, octet_stb, packet_stb;
  logic        repeater_reset_bit, mgmt_reset_bit, expansion_port_bit, exp_mac_pkt;
  logic        sa_change, exp_count_ok;
  logic [3:0]  pkt_port, lsa_wr_port, sa_change_port;
  logic [14:0] sa_change_invalid;
  logic [47:0] pkt_sa, pref_sa, lsa_wr_data;
  int          mismatches, samples_checked;

  rpc_np_model np_u (.mclk(mclk), .np_cmd_sel(np_cmd_sel), .np_wr(np_wr),
    .np_rd(np_rd), .np_din(np_din), .np_dout(np_dout));

  rpc_top dut_u (.mclk(mclk), .nrst(nrst), .external_port_enable_pin(pin),
    .np_cmd_sel(np_cmd_sel), .np_wr(np_wr), .np_rd(np_rd), .np_din(np_din),
    .np_dout(np_dout), .rx_act(rx_act), .tx_act(tx_act), .loop_rx(loop_rx),
    .part_ok(part_ok), .link_in(link_in), .pol_in(pol_in),
    .reverse_mode(reverse_mode), .sqe_done(sqe_done), .sqe_err(sqe_err),
    .pkt_done(pkt_done), .pkt_port(pkt_port), .pkt_good(pkt_good),
    .pkt_sa(pkt_sa), .pref_sa(pref_sa), .lsa_wr(lsa_wr),
    .lsa_wr_port(lsa_wr_port), .lsa_wr_data(lsa_wr_data),
    .octet_stb(octet_stb), .packet_stb(packet_stb),
    .repeater_reset_bit(repeater_reset_bit), .mgmt_reset_bit(mgmt_reset_bit),
    .expansion_port_bit(expansion_port_bit), .exp_mac_pkt(exp_mac_pkt),
    .port_connected(port_connected), .rx_gated(rx_gated),
    .repeat_en(repeat_en), .tx_gate(tx_gate), .ext_dist_out(ext_dist_out),
    .link_status(link_status), .pol_status(pol_status),
    .intrusion_disable(intrusion_disable), .sa_change(sa_change),
    .sa_change_port(sa_change_port), .sa_change_invalid(sa_change_invalid),
    .exp_count_ok(exp_count_ok));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic close_out;
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic p);
    @(posedge mclk);
    nrst <= 1'b0;
    pin  <= p;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask : do_reset

  task automatic pkt(input logic [3:0] p, input logic [47:0] s, input logic g);
    @(posedge mclk);
    pkt_done <= 1'b1;
    pkt_port <= p;
    pkt_sa   <= s;
    pkt_good <= g;
    @(posedge mclk);
    pkt_done <= 1'b0;
    #1;
  endtask : pkt

  task automatic lsa_load(input logic [3:0] p, input logic [47:0] s);
    @(posedge mclk);
    lsa_wr      <= 1'b1;
    lsa_wr_port <= p;
    lsa_wr_data <= s;
    @(posedge mclk);
    lsa_wr      <= 1'b0;
  endtask : lsa_load

  task automatic t_reset;
    logic [31:0] v;
    do_reset(1'b0);
    chk(port_connected, 32'h0);
    np_u.rdn(`RPC_BANK_CTRL, `RPC_OFS_ISO, 2, v);
    chk(v, 32'h0);
    do_reset(1'b1);
    chk(port_connected, 32'h3FFF);
    np_u.rdn(`RPC_BANK_CTRL, `RPC_OFS_ISO, 2, v);
    chk(v, 32'h3FFF);
    for (int a = 8'hE8; a <= 8'hEB; a++) begin
      np_u.rdn(`RPC_BANK_CTRL, 8'(a), 2, v);
      chk(v, 32'h0);
    end
    chk(ext_dist_out, 32'h0);
  endtask : t_reset

  task automatic t_iso;
    @(posedge mclk);
    rx_act <= 14'h0008;
    np_u.wrn(`RPC_BANK_CTRL, `RPC_OFS_ISO, 2, 32'h3FF7);
    repeat (2) @(posedge mclk);
    #1;
    chk(port_connected, 32'h3FF7);
    chk(rx_gated, 32'h0);
    chk(link_status, 32'(link_in));
    np_u.wrn(`RPC_BANK_CTRL, `RPC_OFS_ISO, 2, 32'h3FFF);
    repeat (2) @(posedge mclk);
    #1;
    chk(port_connected, 32'h3FF7);
    @(posedge mclk);
    rx_act  <= 14'h0030;
    part_ok <= 14'h3FEF;
    repeat (2) @(posedge mclk);
    #1;
    chk(port_connected, 32'h3FFF);
    chk(repeat_en, 32'h0020);
    chk(tx_gate, 32'h3FFF);
    @(posedge mclk);
    rx_act <= 14'h0;
  endtask : t_iso

  task automatic t_ext;
    logic [31:0] v;
    np_u.wrn(`RPC_BANK_CTRL, `RPC_OFS_EXT, 2, 32'hA55A);
    #1;
    chk(ext_dist_out, 32'hA55A);
    np_u.rdn(`RPC_BANK_CTRL, `RPC_OFS_EXT, 2, v);
    chk(v, 32'hA55A);
    np_u.rdn(`RPC_BANK_CTRL, 8'hF5, 1, v);
    chk(v, 32'h0);
  endtask : t_ext

  task automatic t_intr;
    logic [3:0] hit_a;
    logic [3:0] hit_c;
    hit_a = 4'b0100;
    hit_c = 4'b1110;
    for (int m = 0; m < 4; m++) begin
      lsa_load(4'd2, 48'hA1);
      np_u.wrn(`RPC_BANK_CTRL, `RPC_OFS_LIE, 2, 32'(m % 2) << 2);
      np_u.wrn(`RPC_BANK_CTRL, `RPC_OFS_PIE, 2, 32'(m / 2) << 2);
      pkt(4'd2, 48'hA1, 1'b1);
      chk(intrusion_disable, 32'(hit_a[m]) << 2);
      pkt(4'd2, 48'hC3, 1'b1);
      chk(intrusion_disable, 32'(hit_c[m]) << 2);
    end
    pkt(4'd2, 48'hD4, 1'b0);
    chk(intrusion_disable, 32'h0);
    np_u.wrn(`RPC_BANK_CTRL, `RPC_OFS_LIE, 2, 32'h0);
    np_u.wrn(`RPC_BANK_CTRL, `RPC_OFS_PIE, 2, 32'h0);
  endtask : t_intr

  task automatic t_lsa;
    lsa_load(4'd5, 48'h11);
    pkt(4'd5, 48'h22, 1'b1);
    chk({sa_change, sa_change_port}, 32'h15);
    pkt(4'd5, 48'h22, 1'b1);
    chk(sa_change, 32'h0);
    np_u.wrn(`RPC_BANK_CTRL, `RPC_OFS_LCK, 2, 32'h4020);
    @(posedge mclk);
    #1;
    chk(sa_change_invalid, 32'h4020);
    pkt(4'd5, 48'h33, 1'b1);
    chk(sa_change, 32'h0);
    lsa_load(4'd5, 48'h44);
    np_u.wrn(`RPC_BANK_CTRL, `RPC_OFS_LCK, 2, 32'h0);
    pkt(4'd5, 48'h44, 1'b1);
    chk(sa_change, 32'h0);
  endtask : t_lsa

  task automatic t_stat;
    logic [31:0] v;
    logic [7:0]  ad [5] = '{8'hE0, 8'hE2, 8'hE3, 8'hE4, 8'hE5};
    logic [15:0] ex [5] = '{16'h1234, 16'hBEEF, 16'h0002, 16'h0F0F, 16'h0010};
    @(posedge mclk);
    part_ok      <= 14'h1234;
    link_in      <= 16'hBEEF;
    pol_in       <= 16'h0F0F;
    tx_act       <= 14'h2006;
    loop_rx      <= 14'h0004;
    reverse_mode <= 1'b1;
    sqe_done     <= 14'h2010;
    sqe_err      <= 14'h2010;
    @(posedge mclk);
    sqe_done <= 14'h0;
    repeat (3) @(posedge mclk);
    tx_act <= 14'h0;
    repeat (2) @(posedge mclk);
    np_u.wrn(`RPC_BANK_STAT, `RPC_OFS_PART, 2, 32'h0);
    for (int i = 0; i < 5; i++) begin
      np_u.rdn(`RPC_BANK_STAT, ad[i], 2, v);
      chk(v, 32'(ex[i]));
    end
    chk(pol_status, 32'h0F0F);
    @(posedge mclk);
    reverse_mode <= 1'b0;
  endtask : t_stat

  task automatic t_cnt;
    logic [31:0] v;
    @(posedge mclk);
    octet_stb <= 1'b1;
    repeat (5) @(posedge mclk);
    octet_stb  <= 1'b0;
    packet_stb <= 1'b1;
    repeat (2) @(posedge mclk);
    packet_stb <= 1'b0;
    np_u.rdn(`RPC_BANK_RMON, `RPC_OFS_OCT, 4, v);
    chk(v, 32'h5);
    np_u.rdn(`RPC_BANK_RMON, `RPC_OFS_PKT, 4, v);
    chk(v, 32'h2);
    np_u.wrn(`RPC_BANK_RMON, `RPC_OFS_OCT, 4, 32'h1234_5678);
    np_u.rdn(`RPC_BANK_RMON, `RPC_OFS_OCT, 4, v);
    chk(v, 32'h5);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      {repeater_reset_bit, mgmt_reset_bit} <= 2'(i + 1);
      np_u.wrn(`RPC_BANK_RMON, 8'(8'hE0 + i), 4, 32'hCAFE_0001 + i);
      np_u.rdn(`RPC_BANK_RMON, 8'(8'hE0 + i), 4, v);
      chk(v, 32'hCAFE_0001 + i);
    end
    @(posedge mclk);
    {repeater_reset_bit, mgmt_reset_bit} <= 2'b00;
  endtask : t_cnt

  task automatic t_exp;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      {expansion_port_bit, exp_mac_pkt} <= 2'(i);
      @(posedge mclk);
      #1;
      chk(exp_count_ok, 32'(i / 2 | ~(i % 2) & 1));
    end
  endtask : t_exp

  initial begin
    {nrst, pin, rx_act, tx_act, loop_rx, sqe_done, sqe_err, reverse_mode,
     pkt_done, pkt_good, lsa_wr, octet_stb, packet_stb, repeater_reset_bit,
     mgmt_reset_bit, expansion_port_bit, exp_mac_pkt, pkt_port, lsa_wr_port,
     pkt_sa, lsa_wr_data, pol_in} = '0;
    part_ok = 14'h3FFF;
    link_in = 16'h5A5A;
    pref_sa = 48'hB2;
    mismatches = 0;
    samples_checked = 0;
    t_reset;
    t_iso;
    t_ext;
    t_intr;
    t_lsa;
    t_stat;
    t_cnt;
    t_exp;
    close_out;
  end

  // Whole run needs a few hundred cycles
  initial begin
    #50000;
    mismatches++;
    close_out;
  end
endmodule : testbench

`default_nettype wire
